// File: sbrg_pkg.sv
// package: register map, field positions, reset values and timing constants for the baud generator
package sbrg_pkg;

  localparam logic [31:0] SBRG_OFS_TXCS = 32'h0000_0000;
  localparam logic [31:0] SBRG_OFS_RXCS = 32'h0000_0004;
  localparam logic [31:0] SBRG_OFS_DIV  = 32'h0000_0008;
  localparam logic [31:0] SBRG_OFS_STAT = 32'h0000_000C;

  localparam int SBRG_TX_CLOCK_SOURCE_SELECT_BIT = 7;
  localparam int SBRG_TX_SYNC_BIT = 4;
  localparam int SBRG_TX_HIGH_SPEED_SELECT_BIT = 2;
  localparam int SBRG_TX_TRMT_BIT = 1;
  localparam int SBRG_RX_SERIAL_PORT_ENABLE_BIT = 7;

  // writable masks: bit 3 of tx is unimplemented, trmt and the rx error bits are read-only
  localparam logic [7:0] SBRG_TX_WMASK = 8'hF5;
  localparam logic [7:0] SBRG_RX_WMASK = 8'hF8;

  localparam logic [7:0] SBRG_TX_RST  = 8'h02;
  localparam logic [7:0] SBRG_RX_RST  = 8'h00;
  localparam logic [7:0] SBRG_DIV_RST = 8'h00;

  // prescale of the timer tick down to one bit period
  localparam int SBRG_PRE_ASYNC_LO = 64;
  localparam int SBRG_PRE_ASYNC_HI = 16;
  localparam int SBRG_PRE_SYNC     = 4;
  localparam int SBRG_PRE_W        = 6;

  localparam logic [1:0] SBRG_RESP_OKAY   = 2'b00;
  localparam logic [1:0] SBRG_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       bit_tick;
    logic       bit_clk;
    logic       clk_internal;
    logic       rx_level;
  } sbrg_out_t;

endpackage

// File: sbrg_top.sv
// baud rate generator with receive-pin majority sampler and axi4-lite registers
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module sbrg_top
  import sbrg_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        receive_data_pin,
  output sbrg_out_t        gen_out
);

  // ---------------- bus and register state ----------------
  logic        aw_got_q, aw_got_d;
  logic        w_got_q,  w_got_d;
  logic [31:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q,  wdata_d;
  logic        wstrb0_q, wstrb0_d;
  logic        awready_q, awready_d;
  logic        wready_q,  wready_d;
  logic        bvalid_q,  bvalid_d;
  logic [1:0]  bresp_q,   bresp_d;
  logic        arready_q, arready_d;
  logic        rvalid_q,  rvalid_d;
  logic [31:0] rdata_q,   rdata_d;
  logic [1:0]  rresp_q,   rresp_d;
  logic [7:0]  tx_control_status_q, tx_control_status_d;
  logic [7:0]  rx_control_status_q, rx_control_status_d;
  logic [7:0]  baud_divisor_q, baud_divisor_d;
  logic        div_write;

  // ---------------- generator state ----------------
  logic [7:0]            timer_q, timer_d;
  logic [SBRG_PRE_W-1:0] pre_q, pre_d;
  logic                  tick;
  logic [SBRG_PRE_W-1:0] pre_last;
  logic                  sync_mode, high_speed_select, clock_source_select;
  logic                  internal_clk, serial_port_enable;
  logic [2:0]            rx_hist_q, rx_hist_d;
  sbrg_out_t             out_q, out_d;

  assign sync_mode           = tx_control_status_q[SBRG_TX_SYNC_BIT];
  assign high_speed_select   = tx_control_status_q[SBRG_TX_HIGH_SPEED_SELECT_BIT];
  assign clock_source_select = tx_control_status_q[SBRG_TX_CLOCK_SOURCE_SELECT_BIT];
  assign serial_port_enable  = rx_control_status_q[SBRG_RX_SERIAL_PORT_ENABLE_BIT];
  // async always uses the generator; sync only as master
  assign internal_clk = !sync_mode || clock_source_select;

  function automatic logic [7:0] reg_write(input logic [7:0] cur, input logic [7:0] wv,
                                           input logic [7:0] mask);
    reg_write = (cur & ~mask) | (wv & mask);
  endfunction

  always_comb begin
    aw_got_d  = aw_got_q;
    w_got_d   = w_got_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    awready_d = 1'b0;
    wready_d  = 1'b0;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = 1'b0;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    tx_control_status_d = tx_control_status_q;
    rx_control_status_d = rx_control_status_q;
    baud_divisor_d      = baud_divisor_q;
    div_write = 1'b0;
    // address and data are taken independently, in either order
    if (s_axi_awvalid && awready_q) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_got_d  = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (!aw_got_d && !awready_q && !bvalid_q) awready_d = !aw_got_q && s_axi_awvalid;
    if (!w_got_d && !wready_q && !bvalid_q)   wready_d  = !w_got_q && s_axi_wvalid;
    if (aw_got_q && w_got_q && !bvalid_q) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = SBRG_RESP_OKAY;
      case (awaddr_q[7:0] & 8'hFC)
        SBRG_OFS_TXCS[7:0]: if (wstrb0_q) tx_control_status_d =
                                reg_write(tx_control_status_q, wdata_q[7:0], SBRG_TX_WMASK);
        SBRG_OFS_RXCS[7:0]: if (wstrb0_q) rx_control_status_d =
                                reg_write(rx_control_status_q, wdata_q[7:0], SBRG_RX_WMASK);
        SBRG_OFS_DIV[7:0]: begin
          if (wstrb0_q) begin
            baud_divisor_d = wdata_q[7:0];
            div_write      = 1'b1;
          end
        end
        SBRG_OFS_STAT[7:0]: bresp_d = SBRG_RESP_OKAY;
        default: bresp_d = SBRG_RESP_SLVERR;
      endcase
      if (awaddr_q[31:8] != 24'h00_0000) bresp_d = SBRG_RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    // read channel
    if (!rvalid_q && !arready_q) arready_d = s_axi_arvalid;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = SBRG_RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case (s_axi_araddr[7:0] & 8'hFC)
        SBRG_OFS_TXCS[7:0]: rdata_d[7:0] = tx_control_status_q;
        SBRG_OFS_RXCS[7:0]: rdata_d[7:0] = rx_control_status_q;
        SBRG_OFS_DIV[7:0]:  rdata_d[7:0] = baud_divisor_q;
        SBRG_OFS_STAT[7:0]: rdata_d[15:0] = {timer_q, 1'b0, pre_q,
                                             out_q.rx_level};
        default: rresp_d = SBRG_RESP_SLVERR;
      endcase
      if (s_axi_araddr[31:8] != 24'h00_0000) begin
        rresp_d = SBRG_RESP_SLVERR;
        rdata_d = 32'h0000_0000;
      end
    end
    if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
      wdata_q   <= 32'h0000_0000;
      wstrb0_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= SBRG_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= SBRG_RESP_OKAY;
      tx_control_status_q <= SBRG_TX_RST;
      rx_control_status_q <= SBRG_RX_RST;
      baud_divisor_q      <= SBRG_DIV_RST;
    end else if (clk_en) begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      tx_control_status_q <= tx_control_status_d;
      rx_control_status_q <= rx_control_status_d;
      baud_divisor_q      <= baud_divisor_d;
    end
  end

  // ---------------- generator ----------------
  // timer counts up 0..divisor, so one tick per divisor+1 clocks
  assign tick = (timer_q == baud_divisor_q);

  always_comb begin
    if (sync_mode)
      pre_last = SBRG_PRE_W'(SBRG_PRE_SYNC - 1);
    else if (high_speed_select)
      pre_last = SBRG_PRE_W'(SBRG_PRE_ASYNC_HI - 1);
    else
      pre_last = SBRG_PRE_W'(SBRG_PRE_ASYNC_LO - 1);
  end

  always_comb begin
    timer_d = tick ? 8'h00 : timer_q + 8'h01;
    pre_d   = pre_q;
    if (tick) pre_d = (pre_q >= pre_last) ? '0 : pre_q + SBRG_PRE_W'(1);
    // a divisor write restarts the whole chain so the new rate starts cleanly
    if (div_write) begin
      timer_d = 8'h00;
      pre_d   = '0;
    end
    rx_hist_d = {rx_hist_q[1:0], receive_data_pin};
    out_d.clk_internal = internal_clk;
    out_d.bit_tick = internal_clk && serial_port_enable && tick && (pre_q >= pre_last);
    // bit clock high in the first half of the prescale period
    out_d.bit_clk  = internal_clk && serial_port_enable && (pre_q <= (pre_last >> 1));
    // majority of three consecutive samples; a single-cycle glitch is rejected
    out_d.rx_level = (rx_hist_q[0] & rx_hist_q[1]) | (rx_hist_q[1] & rx_hist_q[2])
                   | (rx_hist_q[0] & rx_hist_q[2]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_q   <= 8'h00;
      pre_q     <= '0;
      rx_hist_q <= 3'b111;
      out_q     <= '{bit_tick: 1'b0, bit_clk: 1'b0, clk_internal: 1'b1, rx_level: 1'b1};
    end else if (clk_en) begin
      timer_q   <= timer_d;
      pre_q     <= pre_d;
      rx_hist_q <= rx_hist_d;
      out_q     <= out_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign gen_out       = out_q;

endmodule // sbrg_top

// File: sbrg_properties.sv
// port-level assertions for the baud generator block
`timescale 1ns/1ns
module sbrg_checker
  import sbrg_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        receive_data_pin,
  input wire sbrg_out_t   gen_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // five steady samples leave no room for the old level in a vote of three
  a_rx_follow_high: assert property ((receive_data_pin && clk_en)[*5] |=> gen_out.rx_level)
    else $error("rx level not high after steady high pin");
  a_rx_follow_low: assert property ((!receive_data_pin && clk_en)[*5] |=> !gen_out.rx_level)
    else $error("rx level not low after steady low pin");
  a_tick_internal: assert property (gen_out.bit_tick |-> gen_out.clk_internal)
    else $error("bit tick while clock is external");
  a_slave_gated: assert property (!gen_out.clk_internal |-> !gen_out.bit_clk && !gen_out.bit_tick)
    else $error("bit clock active in slave mode");
  // the fastest ratio is four clocks a bit
  a_min_period: assert property (gen_out.bit_tick && clk_en |=> !gen_out.bit_tick[*3])
    else $error("bit ticks closer than four clocks");
  a_reset_idle: assert property ($rose(aresetn) |-> !gen_out.bit_tick && gen_out.clk_internal)
    else $error("outputs not at reset values");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("unused read bits not zero");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
    else $error("read answer missing");

  c_tick: cover property (gen_out.bit_tick);
  c_slave: cover property (!gen_out.clk_internal);
  c_rx_low: cover property (!gen_out.rx_level);
endmodule // sbrg_checker

bind sbrg_top sbrg_checker u_sbrg_checker (.aclk, .aresetn, .clk_en, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .receive_data_pin, .gen_out);

// File: tb_top.sv
// self-checking testbench for the baud generator block
`timescale 1ns/1ns
module tb_top;
  import sbrg_pkg::*;
  logic        aclk = 0, aresetn = 0, clk_en = 1, receive_data_pin = 1;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic        awvalid = 0, awready, wvalid = 0, wready, bvalid, arvalid = 0, arready, rvalid;
  logic [1:0]  bresp, rresp;
  // ready lines stay high: the master always accepts an answer at once
  logic        bready = 1, rready = 1;
  logic [3:0]  wstrb = 4'hF;
  sbrg_out_t   gen_out;
  int          fails = 0, check_count = 0, cycles = 0;

  sbrg_top u_sbrg_top (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .receive_data_pin(receive_data_pin), .gen_out(gen_out));

  always #5 aclk = ~aclk;

  task automatic print_verdict();
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // the whole run needs well under this many cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h000000, d}; awvalid <= 1; wvalid <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !ad) begin ad = 1; awvalid <= 0; end
      if (wready === 1'b1 && !dd) begin dd = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  // cycles until the next bit tick, capped
  task automatic gap(output int n);
    n = 0;
    do begin @(posedge aclk); n++; end while (gen_out.bit_tick !== 1'b1 && n < 5000);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(SBRG_OFS_TXCS, d, r); chk("tx_reset", 32'h00000002, d);
    rd(SBRG_OFS_DIV, d, r); chk("div_reset", 32'h00000000, d);
    wr(SBRG_OFS_TXCS, 8'hFF, r); chk("tx_wresp", SBRG_RESP_OKAY, r);
    rd(SBRG_OFS_TXCS, d, r); chk("tx_mask", 32'h000000F7, d);
    wr(SBRG_OFS_RXCS, 8'hFF, r);
    rd(SBRG_OFS_RXCS, d, r); chk("rx_mask", 32'h000000F8, d);
    wr(SBRG_OFS_DIV, 8'hFF, r);
    rd(SBRG_OFS_DIV, d, r); chk("div_max", 32'h000000FF, d);
    // a write with the low byte lane off must leave the divisor alone
    wstrb <= 4'h0;
    wr(SBRG_OFS_DIV, 8'h11, r);
    wstrb <= 4'hF;
    rd(SBRG_OFS_DIV, d, r); chk("div_nostrobe", 32'h000000FF, d);
    rd(32'h00000010, d, r); chk("unmapped_rresp", SBRG_RESP_SLVERR, r);
    chk("unmapped_rdata", 0, d);
    wr(32'h00000010, 8'h55, r); chk("unmapped_bresp", SBRG_RESP_SLVERR, r);
  endtask

  task automatic t_rates();
    logic [7:0]  txv[4] = '{8'h80, 8'h84, 8'h90, 8'h94};
    logic [7:0]  dv[4] = '{8'h02, 8'h02, 8'h00, 8'h01};
    int          ex[4] = '{SBRG_PRE_ASYNC_LO * 3, SBRG_PRE_ASYNC_HI * 3, SBRG_PRE_SYNC,
                           SBRG_PRE_SYNC * 2};
    logic [1:0]  r;
    int          n;
    wr(SBRG_OFS_RXCS, 8'h80, r);
    for (int i = 0; i < 4; i++) begin
      wr(SBRG_OFS_TXCS, txv[i], r);
      wr(SBRG_OFS_DIV, dv[i], r);
      gap(n);
      gap(n);
      chk("bit_period", ex[i], n);
    end
  endtask

  // sync master, divisor 1: eight clocks a bit; clk_en low must freeze the chain
  task automatic t_freeze();
    int   n;
    int   hi;
    logic seen;
    seen = 0;
    hi   = 0;
    gap(n);
    repeat (8) begin @(posedge aclk); hi = hi + gen_out.bit_clk; end
    chk("bit_clk_half", 4, hi);
    gap(n);
    clk_en <= 0;
    repeat (20) begin @(posedge aclk); seen = seen | gen_out.bit_tick; end
    clk_en <= 1;
    chk("freeze_no_tick", 0, seen);
    gap(n);
    chk("freeze_resume", 8, n);
  endtask

  task automatic t_slave();
    logic [1:0] r;
    int         n;
    wr(SBRG_OFS_TXCS, 8'h10, r);
    gap(n);
    chk("slave_no_tick", 5000, n);
    chk("slave_internal", 0, gen_out.clk_internal);
  endtask

  task automatic t_restart();
    logic [1:0] r;
    int         n;
    wr(SBRG_OFS_TXCS, 8'h84, r);
    wr(SBRG_OFS_DIV, 8'h09, r);
    gap(n);
    repeat (100) @(posedge aclk);
    // same value again: without a timer clear the tick would come about 60 cycles on
    wr(SBRG_OFS_DIV, 8'h09, r);
    gap(n);
    chk("restart_window", 1, n >= 150 && n <= 165);
  endtask

  task automatic t_majority();
    logic seen;
    seen = 0;
    receive_data_pin <= 0;
    repeat (6) @(posedge aclk);
    chk("rx_low", 0, gen_out.rx_level);
    receive_data_pin <= 1;
    @(posedge aclk);
    receive_data_pin <= 0;
    repeat (6) begin @(posedge aclk); seen = seen | gen_out.rx_level; end
    chk("rx_glitch", 0, seen);
    receive_data_pin <= 1;
    repeat (6) @(posedge aclk);
    chk("rx_high", 1, gen_out.rx_level);
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_rates();
    t_freeze();
    t_slave();
    t_restart();
    t_majority();
    print_verdict();
  end
endmodule // tb_top
